/* src/msc_clock_gen.sv */
// Multi-source clock generator: oscillator control, source switch, dividers
// Behaviour
// - Auxiliary clock from crystal or tiny oscillator, divided
// - Master clock from four sources, divided 1-8
// - Sub-main clock: independent select and divider
// - Reset: master/sub-main from DIGITALLY_CONTROLLED_OSC, aux 6pF
// - Tiny oscillator chosen when select 10, LF
// - Crystal disabled while tiny oscillator selected
// - Oscillator-off stops tiny oscillator in deepest mode
// - Load-cap field picks four capacitances in LF
// - HF mode needs hf bit, cap 00
// - Crystal bypass when select 11, on, cap 00
// - Crystal too slow sets crystal fault
// - Oscillator-off ignored while crystal clocks master/sub-main
// - Second-off ignored while second clocks master/sub-main
// - Second bypass when range 11 and on
// - Second too slow sets second fault
// - Clock-gen bit stops DIGITALLY_CONTROLLED_OSC only if unused
// - Reset: DIGITALLY_CONTROLLED_OSC range 7, tap 3
// - Range field picks sixteen DIGITALLY_CONTROLLED_OSC ranges
// - Tap field picks eight steps
// - Modulation mixes next tap; none at tap 7
// - Configuration may change at any time
// - Next tap used modulation cycles of 32
// - Source switch: finish cycle, hold high, resume; aux skips the finish
// - Crystal fault forces master onto DIGITALLY_CONTROLLED_OSC
`timescale 1ns/1ns

// ==========================================================
// Two-flop synchroniser for asynchronous levels
module msc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ==========================================================
// One output clock: glitch-free source switch and divider
module msc_clk_channel
  import msc_pkg::*;
#(
  parameter bit SYNC_SW = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sources, sampled levels and their rising edges
  input wire logic [MSC_NSRC-1:0] src_lvl_i,
  input wire logic [MSC_NSRC-1:0] src_rise_i,
  // Requested setting
  input wire logic [1:0] sel_i,
  input wire logic [1:0] div_i,
  // Output
  output logic clk_o,
  output logic [1:0] cur_sel_o
);
  msc_sw_state_t state_q;
  logic [1:0] cur_div_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic div_out;
  logic cur_rise;
  logic new_rise;

  assign cur_rise = src_rise_i[cur_sel_o];
  assign new_rise = src_rise_i[sel_i];
  assign cnt_d = 3'(cnt_q + 3'h1);

  // Divide by 1, 2, 4, 8 for codes 0..3
  always_comb begin
    if (cur_div_q == 2'h0) begin
      div_out = src_lvl_i[cur_sel_o];
    end else begin
      div_out = cnt_q[cur_div_q - 2'h1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= MSC_RUN;
      cur_sel_o <= MSC_SEL_DCO;
      cur_div_q <= 2'h0;
      cnt_q <= 3'h0;
      clk_o <= 1'b0;
    end else begin
      case (state_q)
        MSC_RUN: begin
          clk_o <= div_out;
          if (cur_rise) begin
            cnt_q <= cnt_d;
            // Divider changes only where all taps fall together
            if (cnt_q == MSC_CNT_LAST) begin
              cur_div_q <= div_i;
            end
          end
          if (sel_i != cur_sel_o) begin
            // Aux skips the finish: its old crystal may already be stopped
            state_q <= SYNC_SW ? MSC_FINISH : MSC_HOLD;
          end
        end
        MSC_FINISH: begin
          if (cur_rise) begin
            cnt_q <= cnt_d;
          end
          clk_o <= div_out;
          // Old cycle ends at its next rising edge, then hold high
          if (div_out && !clk_o) begin
            state_q <= MSC_HOLD;
          end
        end
        MSC_HOLD: begin
          clk_o <= 1'b1;
          // Request may move while held; follow it to avoid a stall
          if (new_rise) begin
            cur_sel_o <= sel_i;
            cur_div_q <= div_i;
            // Preload so the new source starts with a full high period
            if (div_i == 2'h0) begin
              cnt_q <= 3'h0;
            end else begin
              cnt_q <= 3'(3'h1 << (div_i - 2'h1));
            end
            state_q <= MSC_RUN;
          end
        end
        default: begin
          state_q <= MSC_RUN;
        end
      endcase
    end
  end
endmodule

// ==========================================================
// Top level
module msc_clock_gen
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Oscillator clocks and health, asynchronous
  input wire logic digital_osc_clock_i,
  input wire logic second_crystal_clock_i,
  input wire logic crystal_osc_clock_i,
  input wire logic tiny_power_osc_clock_i,
  input wire logic crystal_ok_i,
  input wire logic second_ok_i,
  // Oscillator control
  output msc_osc_ctl_t osc_ctl_o,
  // Generated clocks
  output logic aux_clock_o,
  output logic master_clock_o,
  output logic submain_clock_o
);
  // ==========================================================
  // Registers
  logic [2:0] tap_select_q;
  logic [4:0] modulation_select_q;
  logic second_osc_off_q;
  logic hf_mode_select_q;
  logic [1:0] aux_div_q;
  logic [3:0] range_select_q;
  logic [1:0] master_sel_q;
  logic [1:0] master_div_q;
  logic [1:0] submain_sel_q;
  logic [1:0] submain_div_q;
  logic [1:0] second_range_select_q;
  logic [1:0] lf_source_select_q;
  logic [1:0] load_cap_select_q;
  logic cpu_off_q;
  logic oscillator_off_q;
  logic sys_clock_gen_0_q;
  logic sys_clock_gen_1_q;
  logic osc_fault_flag_q;
  logic crystal_fault_q;
  logic second_osc_fault_q;
  logic [4:0] mod_cnt_q;
  logic [MSC_NSRC-1:0] src_prev_q;

  // ==========================================================
  // Synchronised inputs
  logic [MSC_NSRC-1:0] src_lvl;
  logic [MSC_NSRC-1:0] src_rise;
  logic [1:0] ok_s;

  msc_sync #(.W(MSC_NSRC)) u_src_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({tiny_power_osc_clock_i, crystal_osc_clock_i,
          second_crystal_clock_i, digital_osc_clock_i}),
    .q_o(src_lvl)
  );

  msc_sync #(.W(2)) u_ok_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({second_ok_i, crystal_ok_i}),
    .q_o(ok_s)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_lvl;
    end
  end

  assign src_rise = src_lvl & ~src_prev_q;

  // ==========================================================
  // Source decode and fault override
  logic tpo_selected;
  logic [1:0] aux_sel;
  logic [1:0] master_eff_sel;
  logic [1:0] master_cur;
  logic [1:0] submain_cur;
  logic deepest_low_power_mode;
  logic used_dco;
  logic used_hf2;
  logic used_lfxt;

  assign tpo_selected = (lf_source_select_q == MSC_LF_SRC_TPO) && !hf_mode_select_q;
  assign aux_sel = tpo_selected ? MSC_SEL_TPO : MSC_SEL_LFXT;

  // Software select stays untouched; only the effective source moves
  always_comb begin
    master_eff_sel = master_sel_q;
    if ((master_sel_q == MSC_SEL_LFXT && crystal_fault_q) ||
        (master_sel_q == MSC_SEL_HF2 && second_osc_fault_q)) begin
      master_eff_sel = MSC_SEL_DCO;
    end
  end

  assign deepest_low_power_mode = cpu_off_q && oscillator_off_q &&
    sys_clock_gen_0_q && sys_clock_gen_1_q;
  assign used_dco = (master_cur == MSC_SEL_DCO) || (submain_cur == MSC_SEL_DCO) ||
    (master_sel_q == MSC_SEL_DCO) || (submain_sel_q == MSC_SEL_DCO);
  assign used_hf2 = (master_cur == MSC_SEL_HF2) || (submain_cur == MSC_SEL_HF2) ||
    (master_sel_q == MSC_SEL_HF2) || (submain_sel_q == MSC_SEL_HF2);
  assign used_lfxt = (master_cur == MSC_SEL_LFXT) || (submain_cur == MSC_SEL_LFXT) ||
    (master_sel_q == MSC_SEL_LFXT) || (submain_sel_q == MSC_SEL_LFXT);

  // ==========================================================
  // Oscillator control, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_ctl_o <= '0;
    end else begin
      // Tiny oscillator replaces the crystal outright
      osc_ctl_o.lfxt_en <= !tpo_selected && (!oscillator_off_q || used_lfxt);
      osc_ctl_o.lfxt_hf <= hf_mode_select_q && (load_cap_select_q == MSC_CAP_NONE);
      osc_ctl_o.lfxt_bypass <= (lf_source_select_q == MSC_EXT_CLOCK) &&
        !oscillator_off_q && (load_cap_select_q == MSC_CAP_NONE);
      osc_ctl_o.lfxt_cap <= hf_mode_select_q ? MSC_CAP_NONE : load_cap_select_q;
      osc_ctl_o.lfxt_range <= lf_source_select_q;
      osc_ctl_o.hf2_en <= !second_osc_off_q || used_hf2;
      osc_ctl_o.hf2_bypass <= (second_range_select_q == MSC_EXT_CLOCK) &&
        !second_osc_off_q;
      osc_ctl_o.hf2_range <= second_range_select_q;
      osc_ctl_o.tpo_en <= tpo_selected && !(oscillator_off_q && deepest_low_power_mode);
      osc_ctl_o.dco_en <= !sys_clock_gen_0_q || used_dco;
      osc_ctl_o.dco_range <= range_select_q;
      // Upper tap for the first modulation counts of each 32-cycle frame
      if (tap_select_q != MSC_TAP_MAX && mod_cnt_q < modulation_select_q) begin
        osc_ctl_o.dco_tap <= 3'(tap_select_q + 3'h1);
      end else begin
        osc_ctl_o.dco_tap <= tap_select_q;
      end
    end
  end

  // Modulation frame counts DIGITALLY_CONTROLLED_OSC cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt_q <= '0;
    end else if (src_rise[MSC_IDX_DCO]) begin
      mod_cnt_q <= (mod_cnt_q == MSC_MOD_LAST) ? 5'h00 : 5'(mod_cnt_q + 5'h01);
    end
  end

  // ==========================================================
  // Faults: live while an enabled crystal is unhealthy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crystal_fault_q <= 1'b0;
      second_osc_fault_q <= 1'b0;
    end else begin
      crystal_fault_q <= osc_ctl_o.lfxt_en && !ok_s[0];
      second_osc_fault_q <= osc_ctl_o.hf2_en && !ok_s[1];
    end
  end

  // ==========================================================
  // Clock channels
  msc_clk_channel #(.SYNC_SW(1'b0)) u_aux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_lvl),
    .src_rise_i(src_rise),
    .sel_i(aux_sel),
    .div_i(aux_div_q),
    .clk_o(aux_clock_o),
    .cur_sel_o()
  );

  msc_clk_channel u_master (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_lvl),
    .src_rise_i(src_rise),
    .sel_i(master_eff_sel),
    .div_i(master_div_q),
    .clk_o(master_clock_o),
    .cur_sel_o(master_cur)
  );

  msc_clk_channel u_submain (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_lvl_i(src_lvl),
    .src_rise_i(src_rise),
    .sel_i(submain_sel_q),
    .div_i(submain_div_q),
    .clk_o(submain_clock_o),
    .cur_sel_o(submain_cur)
  );

  // ==========================================================
  // Wishbone register access
  logic req;
  logic wr;
  logic [7:0] wd;
  logic [7:0] rd;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign wd = dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {tap_select_q, modulation_select_q} <= MSC_DCO_CTL_RST;
      {second_osc_off_q, hf_mode_select_q, aux_div_q, range_select_q} <= MSC_CTL1_RST;
      {master_sel_q, master_div_q, submain_sel_q, submain_div_q} <= MSC_CTL2_RST;
      {second_range_select_q, lf_source_select_q, load_cap_select_q} <=
        MSC_CTL3_RST[7:2];
      {sys_clock_gen_1_q, sys_clock_gen_0_q, oscillator_off_q, cpu_off_q} <=
        MSC_MODE_RST[3:0];
    end else if (wr) begin
      if (adr_i == MSC_DCO_CTL_OFS) begin
        {tap_select_q, modulation_select_q} <= wd;
      end else if (adr_i == MSC_CTL1_OFS) begin
        {second_osc_off_q, hf_mode_select_q, aux_div_q, range_select_q} <= wd;
      end else if (adr_i == MSC_CTL2_OFS) begin
        {master_sel_q, master_div_q, submain_sel_q, submain_div_q} <= wd;
      end else if (adr_i == MSC_CTL3_OFS) begin
        {second_range_select_q, lf_source_select_q, load_cap_select_q} <= wd[7:2];
      end else if (adr_i == MSC_MODE_OFS) begin
        {sys_clock_gen_1_q, sys_clock_gen_0_q, oscillator_off_q, cpu_off_q} <= wd[3:0];
      end
    end
  end

  // Sticky flag: set at reset and on any fault; a new fault beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_fault_flag_q <= 1'b1;
    end else if (crystal_fault_q || second_osc_fault_q) begin
      osc_fault_flag_q <= 1'b1;
    end else if (wr && adr_i == MSC_FLAG_OFS && wd[0]) begin
      osc_fault_flag_q <= 1'b0;
    end
  end

  always_comb begin
    rd = 8'h00;
    if (adr_i == MSC_DCO_CTL_OFS) begin
      rd = {tap_select_q, modulation_select_q};
    end else if (adr_i == MSC_CTL1_OFS) begin
      rd = {second_osc_off_q, hf_mode_select_q, aux_div_q, range_select_q};
    end else if (adr_i == MSC_CTL2_OFS) begin
      rd = {master_sel_q, master_div_q, submain_sel_q, submain_div_q};
    end else if (adr_i == MSC_CTL3_OFS) begin
      rd = {second_range_select_q, lf_source_select_q, load_cap_select_q,
            second_osc_fault_q, crystal_fault_q};
    end else if (adr_i == MSC_MODE_OFS) begin
      rd = {4'h0, sys_clock_gen_1_q, sys_clock_gen_0_q, oscillator_off_q, cpu_off_q};
    end else if (adr_i == MSC_FLAG_OFS) begin
      rd = {2'h0, submain_cur, master_cur, 1'b0, osc_fault_flag_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (req && !we_i) begin
      dat_o <= {24'h000000, rd};
    end else begin
      dat_o <= '0;
    end
  end
endmodule

/* include/msc_pkg.sv */
// Package for the multi-source clock generator: register map, fields, types
package msc_pkg;

  // ==========================================================
  // Register word offsets (byte addresses)
  localparam logic [7:0] MSC_DCO_CTL_OFS = 8'h00;
  localparam logic [7:0] MSC_CTL1_OFS = 8'h04;
  localparam logic [7:0] MSC_CTL2_OFS = 8'h08;
  localparam logic [7:0] MSC_CTL3_OFS = 8'h0c;
  localparam logic [7:0] MSC_MODE_OFS = 8'h10;
  localparam logic [7:0] MSC_FLAG_OFS = 8'h14;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MSC_DCO_CTL_RST = 8'h60;
  localparam logic [7:0] MSC_CTL1_RST = 8'h87;
  localparam logic [7:0] MSC_CTL2_RST = 8'h00;
  localparam logic [7:0] MSC_CTL3_RST = 8'h04;
  localparam logic [7:0] MSC_MODE_RST = 8'h00;

  // ==========================================================
  // Field values
  localparam logic [1:0] MSC_SEL_DCO = 2'h0;
  localparam logic [1:0] MSC_SEL_HF2 = 2'h1;
  localparam logic [1:0] MSC_SEL_LFXT = 2'h2;
  localparam logic [1:0] MSC_SEL_TPO = 2'h3;
  localparam logic [1:0] MSC_LF_SRC_TPO = 2'h2;
  localparam logic [1:0] MSC_EXT_CLOCK = 2'h3;
  localparam logic [1:0] MSC_CAP_NONE = 2'h0;
  localparam logic [2:0] MSC_TAP_MAX = 3'h7;
  localparam logic [4:0] MSC_MOD_LAST = 5'h1f;
  localparam logic [2:0] MSC_CNT_LAST = 3'h7;
  localparam int MSC_NSRC = 4;

  // Synchronised source index
  localparam int MSC_IDX_DCO = 0;
  localparam int MSC_IDX_HF2 = 1;
  localparam int MSC_IDX_LFXT = 2;
  localparam int MSC_IDX_TPO = 3;

  // ==========================================================
  // Control bundle sent to the analog oscillators
  typedef struct packed {
    logic lfxt_en;
    logic lfxt_hf;
    logic lfxt_bypass;
    logic [1:0] lfxt_cap;
    logic [1:0] lfxt_range;
    logic hf2_en;
    logic hf2_bypass;
    logic [1:0] hf2_range;
    logic tpo_en;
    logic dco_en;
    logic [3:0] dco_range;
    logic [2:0] dco_tap;
  } msc_osc_ctl_t;

  typedef enum logic [1:0] {
    MSC_RUN,
    MSC_FINISH,
    MSC_HOLD
  } msc_sw_state_t;

endpackage

/* testbench/msc_clock_gen_monitor.sv */
// Bus and oscillator-control checks for the clock generator top
`timescale 1ns/1ns
module msc_clock_gen_monitor
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Oscillator control
  input wire msc_osc_ctl_t osc_ctl_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Bus answers
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper_zero: assert property (dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");

  // ==========================================================
  // Oscillator control
  a_reset_dflt: assert property ($fell(rst_i) |=> osc_ctl_o.dco_en && osc_ctl_o.lfxt_en
    && !osc_ctl_o.hf2_en && osc_ctl_o.dco_range == 4'h7 && osc_ctl_o.dco_tap == 3'h3
    && osc_ctl_o.lfxt_cap == 2'h1)
    else $error("wrong oscillator control after reset");
  a_lf_ext_clk: assert property (osc_ctl_o.lfxt_bypass |->
    osc_ctl_o.lfxt_range == MSC_EXT_CLOCK && osc_ctl_o.lfxt_cap == MSC_CAP_NONE)
    else $error("crystal bypass with wrong fields");
  a_hf2_ext_clk: assert property (osc_ctl_o.hf2_bypass |->
    osc_ctl_o.hf2_range == MSC_EXT_CLOCK && osc_ctl_o.hf2_en)
    else $error("second bypass with wrong fields");
  a_tpo_xtal_off: assert property ((osc_ctl_o.tpo_en && !osc_ctl_o.lfxt_hf
    && osc_ctl_o.lfxt_range == MSC_LF_SRC_TPO) |-> !osc_ctl_o.lfxt_en)
    else $error("crystal on while tiny oscillator selected");

  c_bus: cover property (cyc_i && stb_i ##1 ack_o);
  c_tpo: cover property (osc_ctl_o.tpo_en);
  c_hf2_ext: cover property (osc_ctl_o.hf2_bypass);
endmodule

bind msc_clock_gen msc_clock_gen_monitor msc_clock_gen_monitor_inst (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .osc_ctl_o(osc_ctl_o)
);

/* testbench/msc_osc_model.sv */
// Behavioural oscillators and crystal health for the clock generator
`timescale 1ns/1ns
module msc_osc_model
  import msc_pkg::*;
#(
  parameter int DCO_HALF = 203,
  parameter int HF2_HALF = 261,
  parameter int LF_HALF = 341,
  parameter int TPO_HALF = 483
) (
  // Control and fault injection
  input wire msc_osc_ctl_t ctl_i,
  input wire logic xt_bad_i,
  // Oscillators
  output logic dco_o,
  output logic hf2_o,
  output logic lf_o,
  output logic tpo_o,
  output logic xt_ok_o,
  output logic hf2_ok_o
);
  // ==========================================================
  // Odd half periods keep edges off the system clock edges
  initial begin
    dco_o = 1'b0;
    hf2_o = 1'b0;
    lf_o = 1'b0;
    tpo_o = 1'b0;
  end
  // A stopped oscillator stands low
  always #DCO_HALF dco_o = ctl_i.dco_en ? ~dco_o : 1'b0;
  always #HF2_HALF hf2_o = (ctl_i.hf2_en || ctl_i.hf2_bypass) ? ~hf2_o : 1'b0;
  always #LF_HALF lf_o = (ctl_i.lfxt_en || ctl_i.lfxt_bypass) ? ~lf_o : 1'b0;
  always #TPO_HALF tpo_o = ctl_i.tpo_en ? ~tpo_o : 1'b0;
  assign xt_ok_o = !xt_bad_i;
  assign hf2_ok_o = 1'b1;
endmodule

/* testbench/test_multi_source_clock_generator.sv */
// Self-checking bench for the multi-source clock generator
`timescale 1ns/1ns
module test_multi_source_clock_generator;
  import msc_pkg::*;
  // ==========================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o, dco_c, hf2_c, lf_c, tpo_c, xt_ok, hf2_ok;
  logic aux_clock_o, master_clock_o, submain_clock_o;
  logic xt_bad = 1'b0;
  msc_osc_ctl_t osc_ctl_o;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  logic [7:0] rv[6] = '{8'h60, 8'h87, 8'h00, 8'h04, 8'h00, 8'h01};
  int fails = 0;
  int n_tests = 0;
  int k;
  integer seed = 32'he2118719;

  always #20 clk_i = ~clk_i;

  msc_clock_gen msc_clock_gen_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .digital_osc_clock_i(dco_c), .second_crystal_clock_i(hf2_c),
    .crystal_osc_clock_i(lf_c), .tiny_power_osc_clock_i(tpo_c), .crystal_ok_i(xt_ok),
    .second_ok_i(hf2_ok), .osc_ctl_o(osc_ctl_o), .aux_clock_o(aux_clock_o),
    .master_clock_o(master_clock_o), .submain_clock_o(submain_clock_o));
  msc_osc_model msc_osc_model_inst (.ctl_i(osc_ctl_o), .xt_bad_i(xt_bad), .dco_o(dco_c),
    .hf2_o(hf2_c), .lf_o(lf_c), .tpo_o(tpo_c), .xt_ok_o(xt_ok), .hf2_ok_o(hf2_ok));

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= {24'h0, d};
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (i >= 50) begin
      fails++;
      print_verdict();
    end
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask
  // Period of the tenth cycle: a divider change may wait eight old cycles
  task automatic per(input int w, input int ns);
    int n, q, t;
    logic p, c;
    n = 0;
    q = 0;
    t = 0;
    p = 1'b1;
    while (q < 10 && t < 2000) begin
      @(negedge clk_i);
      c = (w == 0) ? master_clock_o : (w == 1) ? submain_clock_o : aux_clock_o;
      n++;
      t++;
      if (c === 1'b1 && p === 1'b0) begin
        q++;
        if (q < 10) n = 0;
      end
      p = c;
    end
    cmp({7'h0, q == 10 && n * 40 > ns - 80 && n * 40 < ns + 80}, 8'h01);
  endtask
  task automatic tapcnt(input logic [2:0] v);
    k = 0;
    repeat (320) begin
      @(negedge clk_i);
      if (osc_ctl_o.dco_tap === v) k++;
    end
  endtask

  // Read results are compared in order of issue
  always @(negedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      cmp(dat_o[7:0], exp_q.pop_front());
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), rv[i]);
    wr(8'h18, 8'hff);
    rd(8'h18, 8'h00);
    wr(MSC_FLAG_OFS, 8'h01);
    rd(MSC_FLAG_OFS, 8'h00);
    $display("Test reset values done");
    for (int d = 0; d < 4; d++) begin
      wr(MSC_CTL2_OFS, {2'h0, d[1:0], 2'h0, d[1:0]});
      wr(MSC_CTL1_OFS, {2'h2, d[1:0], 4'h7});
      per(0, 406 << d);
      per(1, 406 << d);
      per(2, 682 << d);
    end
    wr(MSC_CTL2_OFS, 8'h00);
    wr(MSC_CTL1_OFS, 8'h87);
    $display("Test dividers done");
    wr(MSC_CTL2_OFS, {MSC_SEL_LFXT, 6'h0});
    per(0, 682);
    rd(MSC_FLAG_OFS, {4'h0, MSC_SEL_LFXT, 2'h0});
    wr(MSC_MODE_OFS, 8'h02);
    settle();
    cmp({7'h0, osc_ctl_o.lfxt_en}, 8'h01);
    xt_bad <= 1'b1;
    settle();
    rd(MSC_CTL3_OFS, 8'h05);
    rd(MSC_CTL2_OFS, 8'h80);
    per(0, 406);
    rd(MSC_FLAG_OFS, 8'h01);
    xt_bad <= 1'b0;
    wr(MSC_CTL2_OFS, 8'h00);
    settle();
    cmp({7'h0, osc_ctl_o.lfxt_en}, 8'h00);
    wr(MSC_MODE_OFS, 8'h00);
    wr(MSC_FLAG_OFS, 8'h01);
    $display("Test crystal switch and fault done");
    wr(MSC_CTL1_OFS, 8'h07);
    wr(MSC_CTL2_OFS, {4'h0, MSC_SEL_HF2, 2'h0});
    per(1, 522);
    wr(MSC_CTL1_OFS, 8'h87);
    settle();
    cmp({7'h0, osc_ctl_o.hf2_en}, 8'h01);
    wr(MSC_CTL2_OFS, 8'h00);
    // Switch back must land before the second crystal counts as unused
    per(1, 406);
    cmp({7'h0, osc_ctl_o.hf2_en}, 8'h00);
    $display("Test second crystal done");
    wr(MSC_CTL3_OFS, {2'h0, MSC_LF_SRC_TPO, 4'h4});
    settle();
    cmp({6'h0, osc_ctl_o.tpo_en, osc_ctl_o.lfxt_en}, 8'h02);
    per(2, 966);
    wr(MSC_CTL2_OFS, {MSC_SEL_TPO, 6'h0});
    per(0, 966);
    wr(MSC_CTL2_OFS, 8'h00);
    // Old source must finish its cycle before it is stopped
    per(0, 406);
    wr(MSC_MODE_OFS, 8'h0f);
    settle();
    cmp({7'h0, osc_ctl_o.tpo_en}, 8'h00);
    wr(MSC_CTL3_OFS, 8'h04);
    wr(MSC_MODE_OFS, 8'h04);
    settle();
    cmp({7'h0, osc_ctl_o.dco_en}, 8'h01);
    wr(MSC_CTL2_OFS, 8'h88);
    per(1, 682);
    cmp({7'h0, osc_ctl_o.dco_en}, 8'h00);
    wr(MSC_CTL2_OFS, 8'h00);
    wr(MSC_MODE_OFS, 8'h00);
    $display("Test tiny oscillator and off bits done");
    for (int c = 0; c < 4; c++) begin
      wr(MSC_CTL3_OFS, {4'h0, c[1:0], 2'h0});
      settle();
      cmp({6'h0, osc_ctl_o.lfxt_cap}, {6'h0, c[1:0]});
    end
    wr(MSC_CTL3_OFS, {2'h0, MSC_EXT_CLOCK, MSC_CAP_NONE, 2'h0});
    settle();
    cmp({7'h0, osc_ctl_o.lfxt_bypass}, 8'h01);
    wr(MSC_CTL1_OFS, 8'hc7);
    wr(MSC_CTL3_OFS, 8'h10);
    settle();
    cmp({5'h0, osc_ctl_o.lfxt_hf, osc_ctl_o.lfxt_range}, 8'h05);
    wr(MSC_CTL1_OFS, 8'h07);
    wr(MSC_CTL3_OFS, {MSC_EXT_CLOCK, 6'h04});
    settle();
    cmp({5'h0, osc_ctl_o.hf2_bypass, osc_ctl_o.hf2_range}, 8'h07);
    wr(MSC_CTL1_OFS, 8'h87);
    wr(MSC_CTL3_OFS, 8'h04);
    $display("Test crystal modes done");
    repeat (4) begin
      r = 8'($random(seed));
      wr(MSC_CTL1_OFS, {4'h8, r[3:0]});
      wr(MSC_DCO_CTL_OFS, {r[6:4], 5'h0});
      settle();
      cmp({1'h0, osc_ctl_o.dco_range, osc_ctl_o.dco_tap}, {1'h0, r[3:0], r[6:4]});
    end
    wr(MSC_DCO_CTL_OFS, {MSC_TAP_MAX, MSC_MOD_LAST});
    tapcnt(MSC_TAP_MAX);
    cmp({7'h0, k == 320}, 8'h01);
    wr(MSC_DCO_CTL_OFS, {3'h2, 5'h08});
    tapcnt(3'h3);
    cmp({7'h0, k > 60 && k < 100}, 8'h01);
    $display("Test oscillator tuning done");
    print_verdict();
  end
endmodule
